// ==== verilog/pcfp_pkg.sv ====
package pcfp_pkg;

  localparam int PIN_COUNT = 14;
  localparam int PORT_A_PINS = 6;
  localparam int PORT_B_PINS = 8;
  localparam int FUNC_LEVELS = 5;
  localparam int ALT_COUNT = 4;
  localparam int ADDR_WIDTH = 6;
  localparam int DATA_WIDTH = 32;

  // Register byte offsets
  localparam logic [ADDR_WIDTH-1:0] OFS_PULL_A = 6'h00;
  localparam logic [ADDR_WIDTH-1:0] OFS_PULL_B = 6'h04;
  localparam logic [ADDR_WIDTH-1:0] OFS_SLEW_A = 6'h08;
  localparam logic [ADDR_WIDTH-1:0] OFS_SLEW_B = 6'h0c;
  localparam logic [ADDR_WIDTH-1:0] OFS_DRIVE_A = 6'h10;
  localparam logic [ADDR_WIDTH-1:0] OFS_DRIVE_B = 6'h14;
  localparam logic [ADDR_WIDTH-1:0] OFS_OPTIONS = 6'h18;
  localparam logic [ADDR_WIDTH-1:0] OFS_STATUS = 6'h1c;
  localparam logic [ADDR_WIDTH-1:0] OFS_OE_STATUS = 6'h20;

  // Field positions
  localparam int OPT_TWI_POS_BIT = 0;
  localparam int OPT_DEBUG_PIN_BIT = 1;
  localparam int OPT_WIDTH = 2;
  localparam int STAT_RUN_MODE_BIT = 0;
  localparam int STAT_MODE_TAKEN_BIT = 1;

  // Reset values
  localparam logic [PIN_COUNT-1:0] PULL_RESET = 14'h0000;
  localparam logic [PIN_COUNT-1:0] SLEW_RESET = 14'h3fff;
  localparam logic [PIN_COUNT-1:0] DRIVE_RESET = 14'h0000;
  localparam logic [OPT_WIDTH-1:0] OPTIONS_RESET = 2'h2;
  localparam logic [15:0] RESET_VECTOR = 16'hfffe;

  // Pin indices: port A at 0..5, port B at 6..13
  localparam int PIN_A2 = 2;
  localparam int PIN_A3 = 3;
  localparam int PIN_A4 = 4;
  localparam int PIN_B6 = 12;
  localparam int PIN_B7 = 13;

  // Function slots, lowest priority first
  localparam int SLOT_PORT = 0;
  localparam int SLOT_ALT2 = 2;
  localparam int SLOT_ALT4 = 4;

  typedef struct packed {
    logic en;
    logic oe;
    logic dout;
  } pcfp_req_type;

  typedef struct packed {
    logic dout;
    logic oe;
    logic pull_en;
    logic pull_down;
    logic slew;
    logic high_drive;
  } pcfp_pad_type;

  // Port A sits in the low bits, port B above it
  function automatic logic [DATA_WIDTH-1:0] pcfp_port_slice(
    input logic [PIN_COUNT-1:0] vec,
    input logic is_b
  );
    logic [DATA_WIDTH-1:0] r;
    r = '0;
    if (is_b) begin
      r[PORT_B_PINS-1:0] = vec[PIN_COUNT-1:PORT_A_PINS];
    end else begin
      r[PORT_A_PINS-1:0] = vec[PORT_A_PINS-1:0];
    end
    return r;
  endfunction

  function automatic logic [PIN_COUNT-1:0] pcfp_port_merge(
    input logic [PIN_COUNT-1:0] vec,
    input logic [DATA_WIDTH-1:0] wdata,
    input logic is_b
  );
    logic [PIN_COUNT-1:0] r;
    r = vec;
    if (is_b) begin
      r[PIN_COUNT-1:PORT_A_PINS] = wdata[PORT_B_PINS-1:0];
    end else begin
      r[PORT_A_PINS-1:0] = wdata[PORT_A_PINS-1:0];
    end
    return r;
  endfunction

endpackage

// ==== verilog/pcfp_prio.sv ====
module pcfp_prio (
  input wire pcfp_pkg::pcfp_req_type [pcfp_pkg::FUNC_LEVELS-1:0] req,
  output logic [2:0] owner,
  output logic oe,
  output logic dout
);
  import pcfp_pkg::*;

  // Scanning upward lets the last enabled slot, the highest one, win
  always_comb begin
    owner = 3'(SLOT_PORT);
    oe = req[SLOT_PORT].oe;
    dout = req[SLOT_PORT].dout;
    for (int i = 1; i < FUNC_LEVELS; i++) begin
      if (req[i].en) begin
        owner = 3'(i);
        oe = req[i].oe;
        dout = req[i].dout;
      end
    end
  end

endmodule // pcfp_prio

// ==== verilog/pcfp_pad.sv ====
module pcfp_pad (
  input wire logic oe,
  input wire logic dout,
  input wire logic pull_bit,
  input wire logic slew_bit,
  input wire logic drive_bit,
  input wire logic analog,
  input wire logic kbi_rise,
  output pcfp_pkg::pcfp_pad_type pad
);
  import pcfp_pkg::*;

  always_comb begin
    pad.dout = dout;
    pad.oe = oe & ~analog;
    // Any driver or analog owner turns the pull device off
    pad.pull_en = pull_bit & ~oe & ~analog;
    pad.pull_down = pull_bit & ~oe & ~analog & kbi_rise;
    // Slew limiting only matters while the pin drives
    pad.slew = slew_bit & oe & ~analog;
    pad.high_drive = drive_bit;
  end

endmodule // pcfp_pad

// ==== verilog/pcfp_pin_control.sv ====
module pcfp_pin_control (
  input wire logic sys_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [pcfp_pkg::ADDR_WIDTH-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pcfp_pkg::DATA_WIDTH-1:0] avs_writedata,
  output logic [pcfp_pkg::DATA_WIDTH-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Function requests per pin
  input wire pcfp_pkg::pcfp_req_type [pcfp_pkg::PIN_COUNT-1:0] port_req,
  input wire pcfp_pkg::pcfp_req_type [pcfp_pkg::PIN_COUNT-1:0][pcfp_pkg::ALT_COUNT-1:0] alt_req,
  input wire pcfp_pkg::pcfp_req_type twi_sda_req,
  input wire pcfp_pkg::pcfp_req_type twi_scl_req,
  input wire pcfp_pkg::pcfp_req_type debug_req,
  input wire logic [pcfp_pkg::PIN_COUNT-1:0] kbi_rising,
  input wire logic [pcfp_pkg::PIN_COUNT-1:0] adc_en,
  input wire logic [pcfp_pkg::PIN_COUNT-1:0] analog_comparator_en,
  input wire logic debug_mode_select_pin,
  // Pad side
  output logic [pcfp_pkg::PIN_COUNT-1:0] pad_out,
  output logic [pcfp_pkg::PIN_COUNT-1:0] pad_oe,
  output logic [pcfp_pkg::PIN_COUNT-1:0] pad_pull_en,
  output logic [pcfp_pkg::PIN_COUNT-1:0] pad_pull_down,
  output logic [pcfp_pkg::PIN_COUNT-1:0] pad_slew,
  output logic [pcfp_pkg::PIN_COUNT-1:0] pad_high_drive,
  output logic [pcfp_pkg::PIN_COUNT-1:0] adc_connect,
  output logic [pcfp_pkg::PIN_COUNT-1:0] analog_comparator_connect,
  output logic [2:0] pin_owner [pcfp_pkg::PIN_COUNT],
  output logic run_mode,
  output logic [15:0] vector_fetch_addr
);
  import pcfp_pkg::*;

  // Software pad control bits, one per pin, port A low
  logic [PIN_COUNT-1:0] pull_enable_bits;
  logic [PIN_COUNT-1:0] slew_limit_bits;
  logic [PIN_COUNT-1:0] high_drive_select_bits;
  logic [OPT_WIDTH-1:0] system_options_two;
  logic [PIN_COUNT-1:0] next_pull_enable_bits;
  logic [PIN_COUNT-1:0] next_slew_limit_bits;
  logic [PIN_COUNT-1:0] next_high_drive_select_bits;
  logic [OPT_WIDTH-1:0] next_system_options_two;

  // Bus response state
  logic [DATA_WIDTH-1:0] next_avs_readdata;
  logic next_avs_waitrequest;
  logic bus_req;
  logic bus_accept;
  logic write_hit;

  // Mode capture state: the pin is looked at once, then the result is frozen
  typedef enum logic {
    MODE_WAIT = 1'b0,
    MODE_HELD = 1'b1
  } pcfp_mode_state_type;
  pcfp_mode_state_type mode_state;
  pcfp_mode_state_type next_mode_state;
  logic mode_taken;
  logic next_run_mode;
  logic [15:0] next_vector_fetch_addr;

  // Combinational pad view
  pcfp_req_type [PIN_COUNT-1:0][FUNC_LEVELS-1:0] slot_req;
  logic [PIN_COUNT-1:0] mux_oe;
  logic [PIN_COUNT-1:0] mux_dout;
  logic [2:0] mux_owner [PIN_COUNT];
  logic [PIN_COUNT-1:0] analog_own;
  pcfp_pad_type pad_calc [PIN_COUNT];

  // Next values of the registered pad outputs
  logic [PIN_COUNT-1:0] next_pad_out;
  logic [PIN_COUNT-1:0] next_pad_oe;
  logic [PIN_COUNT-1:0] next_pad_pull_en;
  logic [PIN_COUNT-1:0] next_pad_pull_down;
  logic [PIN_COUNT-1:0] next_pad_slew;
  logic [PIN_COUNT-1:0] next_pad_high_drive;
  logic [PIN_COUNT-1:0] next_adc_connect;
  logic [PIN_COUNT-1:0] next_analog_comparator_connect;
  logic [2:0] next_pin_owner [PIN_COUNT];

  logic two_wire_pin_position_select;
  logic debug_pin_enable;

  assign two_wire_pin_position_select = system_options_two[OPT_TWI_POS_BIT];
  assign debug_pin_enable = system_options_two[OPT_DEBUG_PIN_BIT];
  assign mode_taken = (mode_state == MODE_HELD);

  // Bus handshake
  // A request is answered one cycle after it is seen: waitrequest drops for
  // exactly one cycle, which is the edge at which the master completes.
  assign bus_req = avs_read | avs_write;
  assign bus_accept = bus_req & avs_waitrequest;
  assign write_hit = avs_write & ~avs_waitrequest;

  always_comb begin
    next_avs_waitrequest = ~bus_accept;
    next_avs_readdata = '0;
    if (avs_read && avs_waitrequest) begin
      unique case (avs_address)
        OFS_PULL_A: next_avs_readdata = pcfp_port_slice(pull_enable_bits, 1'b0);
        OFS_PULL_B: next_avs_readdata = pcfp_port_slice(pull_enable_bits, 1'b1);
        OFS_SLEW_A: next_avs_readdata = pcfp_port_slice(slew_limit_bits, 1'b0);
        OFS_SLEW_B: next_avs_readdata = pcfp_port_slice(slew_limit_bits, 1'b1);
        OFS_DRIVE_A: next_avs_readdata = pcfp_port_slice(high_drive_select_bits, 1'b0);
        OFS_DRIVE_B: next_avs_readdata = pcfp_port_slice(high_drive_select_bits, 1'b1);
        OFS_OPTIONS: next_avs_readdata[OPT_WIDTH-1:0] = system_options_two;
        OFS_STATUS: begin
          next_avs_readdata[STAT_RUN_MODE_BIT] = run_mode;
          next_avs_readdata[STAT_MODE_TAKEN_BIT] = mode_taken;
        end
        OFS_OE_STATUS: next_avs_readdata[PIN_COUNT-1:0] = pad_oe;
        // Unmapped addresses read as zero
        default: next_avs_readdata = '0;
      endcase
    end else if (!avs_waitrequest) begin
      next_avs_readdata = avs_readdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      avs_waitrequest <= next_avs_waitrequest;
      avs_readdata <= next_avs_readdata;
    end
  end

  // Pad control registers
  // These bits never look at port data or direction, so each pin is set on
  // its own and a later direction change keeps its pad choice.
  always_comb begin
    next_pull_enable_bits = pull_enable_bits;
    next_slew_limit_bits = slew_limit_bits;
    next_high_drive_select_bits = high_drive_select_bits;
    next_system_options_two = system_options_two;
    if (write_hit) begin
      unique case (avs_address)
        OFS_PULL_A: begin
          next_pull_enable_bits = pcfp_port_merge(pull_enable_bits, avs_writedata, 1'b0);
        end
        OFS_PULL_B: begin
          next_pull_enable_bits = pcfp_port_merge(pull_enable_bits, avs_writedata, 1'b1);
        end
        OFS_SLEW_A: begin
          next_slew_limit_bits = pcfp_port_merge(slew_limit_bits, avs_writedata, 1'b0);
        end
        OFS_SLEW_B: begin
          next_slew_limit_bits = pcfp_port_merge(slew_limit_bits, avs_writedata, 1'b1);
        end
        OFS_DRIVE_A: begin
          next_high_drive_select_bits =
            pcfp_port_merge(high_drive_select_bits, avs_writedata, 1'b0);
        end
        OFS_DRIVE_B: begin
          next_high_drive_select_bits =
            pcfp_port_merge(high_drive_select_bits, avs_writedata, 1'b1);
        end
        OFS_OPTIONS: next_system_options_two = avs_writedata[OPT_WIDTH-1:0];
        // Status words and unmapped addresses ignore writes
        default: next_system_options_two = system_options_two;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pull_enable_bits <= PULL_RESET;
      slew_limit_bits <= SLEW_RESET;
      high_drive_select_bits <= DRIVE_RESET;
      system_options_two <= OPTIONS_RESET;
    end else begin
      pull_enable_bits <= next_pull_enable_bits;
      slew_limit_bits <= next_slew_limit_bits;
      high_drive_select_bits <= next_high_drive_select_bits;
      system_options_two <= next_system_options_two;
    end
  end

  // Run mode selection at reset exit
  // The mode pin is caught on the first clocked cycle after release, not by
  // the reset itself, so the reset path only ever loads constants.
  always_comb begin
    next_mode_state = mode_state;
    next_run_mode = run_mode;
    next_vector_fetch_addr = vector_fetch_addr;
    unique case (mode_state)
      MODE_WAIT: begin
        next_mode_state = MODE_HELD;
        next_run_mode = debug_mode_select_pin;
        next_vector_fetch_addr = debug_mode_select_pin ? RESET_VECTOR : 16'h0000;
      end
      MODE_HELD: begin
        next_mode_state = MODE_HELD;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      mode_state <= MODE_WAIT;
      run_mode <= 1'b0;
      vector_fetch_addr <= 16'h0000;
    end else begin
      mode_state <= next_mode_state;
      run_mode <= next_run_mode;
      vector_fetch_addr <= next_vector_fetch_addr;
    end
  end

  // Slot assembly
  // The two-wire pair and the debug pin are injected into their slots here,
  // overriding whatever the generic alternative inputs carry there.
  always_comb begin
    for (int p = 0; p < PIN_COUNT; p++) begin
      slot_req[p][SLOT_PORT] = port_req[p];
      slot_req[p][SLOT_PORT].en = 1'b1;
      for (int a = 0; a < ALT_COUNT; a++) begin
        slot_req[p][a+1] = alt_req[p][a];
      end
    end
    slot_req[PIN_A2][SLOT_ALT2] = '0;
    slot_req[PIN_A3][SLOT_ALT2] = '0;
    slot_req[PIN_B6][SLOT_ALT2] = '0;
    slot_req[PIN_B7][SLOT_ALT2] = '0;
    if (two_wire_pin_position_select) begin
      slot_req[PIN_B6][SLOT_ALT2] = twi_sda_req;
      slot_req[PIN_B7][SLOT_ALT2] = twi_scl_req;
    end else begin
      slot_req[PIN_A2][SLOT_ALT2] = twi_sda_req;
      slot_req[PIN_A3][SLOT_ALT2] = twi_scl_req;
    end
    slot_req[PIN_A4][SLOT_ALT4] = debug_req;
    slot_req[PIN_A4][SLOT_ALT4].en = debug_pin_enable;
  end

  // Converter and comparator are not ranked against each other: either one
  // takes the pin analog and both stay connected together.
  assign analog_own = adc_en | analog_comparator_en;

  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
    pcfp_prio u_prio (
      .req(slot_req[g]),
      .owner(mux_owner[g]),
      .oe(mux_oe[g]),
      .dout(mux_dout[g])
    );

    pcfp_pad u_pad (
      .oe(mux_oe[g]),
      .dout(mux_dout[g]),
      .pull_bit(pull_enable_bits[g]),
      .slew_bit(slew_limit_bits[g]),
      .drive_bit(high_drive_select_bits[g]),
      .analog(analog_own[g]),
      .kbi_rise(kbi_rising[g]),
      .pad(pad_calc[g])
    );
  end

  // Pad outputs
  // Registered so pads see no decode glitches; costs one cycle of latency
  // from any request change to the pin.
  always_comb begin
    for (int p = 0; p < PIN_COUNT; p++) begin
      next_pad_out[p] = pad_calc[p].dout;
      next_pad_oe[p] = pad_calc[p].oe;
      next_pad_pull_en[p] = pad_calc[p].pull_en;
      next_pad_pull_down[p] = pad_calc[p].pull_down;
      next_pad_slew[p] = pad_calc[p].slew;
      next_pad_high_drive[p] = pad_calc[p].high_drive;
      next_pin_owner[p] = mux_owner[p];
    end
    // Both analog users stay connected; neither is ranked against the other
    next_adc_connect = adc_en;
    next_analog_comparator_connect = analog_comparator_en;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pad_out <= '0;
      pad_oe <= '0;
      pad_pull_en <= '0;
      pad_pull_down <= '0;
      pad_slew <= '0;
      pad_high_drive <= '0;
      adc_connect <= '0;
      analog_comparator_connect <= '0;
      for (int p = 0; p < PIN_COUNT; p++) begin
        pin_owner[p] <= 3'(SLOT_PORT);
      end
    end else begin
      pad_out <= next_pad_out;
      pad_oe <= next_pad_oe;
      pad_pull_en <= next_pad_pull_en;
      pad_pull_down <= next_pad_pull_down;
      pad_slew <= next_pad_slew;
      pad_high_drive <= next_pad_high_drive;
      pin_owner <= next_pin_owner;
      adc_connect <= next_adc_connect;
      analog_comparator_connect <= next_analog_comparator_connect;
    end
  end

endmodule // pcfp_pin_control

// ==== sim/pcfp_pin_control_monitor.sv ====
module pcfp_pin_control_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [pcfp_pkg::PIN_COUNT-1:0] kbi_rising,
  input wire logic [pcfp_pkg::PIN_COUNT-1:0] adc_en,
  input wire logic [pcfp_pkg::PIN_COUNT-1:0] analog_comparator_en,
  input wire logic debug_mode_select_pin,
  input wire logic [pcfp_pkg::PIN_COUNT-1:0] pad_oe,
  input wire logic [pcfp_pkg::PIN_COUNT-1:0] pad_pull_en,
  input wire logic [pcfp_pkg::PIN_COUNT-1:0] pad_pull_down,
  input wire logic [pcfp_pkg::PIN_COUNT-1:0] pad_slew,
  input wire logic [pcfp_pkg::PIN_COUNT-1:0] adc_connect,
  input wire logic [pcfp_pkg::PIN_COUNT-1:0] analog_comparator_connect,
  input wire logic run_mode,
  input wire logic [15:0] vector_fetch_addr
);
  timeunit 1ns;
  timeprecision 1ns;
  import pcfp_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  sequence s_released;
    $rose(rst_n);
  endsequence
  a_bus_one_answer: assert property (s_taken |=> s_answer)
    else $error("bus answer not one cycle");
  a_pull_off_out: assert property ((pad_pull_en & pad_oe) == '0)
    else $error("pull on while driven");
  a_pull_off_analog: assert property (
    $past(rst_n) |-> (pad_pull_en & $past(adc_en | analog_comparator_en)) == '0)
    else $error("pull on while analog");
  a_pulldown_kbi: assert property (pad_pull_down == (pad_pull_en & $past(kbi_rising)))
    else $error("pull direction wrong");
  a_slew_input: assert property ((pad_slew & ~pad_oe) == '0)
    else $error("slew on input pin");
  a_analog_shared: assert property (
    $past(rst_n) |-> adc_connect == $past(adc_en) && analog_comparator_connect == $past(analog_comparator_en))
    else $error("analog access wrong");
  a_mode_capture: assert property (
    s_released |=> run_mode == $past(debug_mode_select_pin))
    else $error("mode not captured");
  // The capture edge itself changes run mode, so stability starts one edge later
  a_mode_stable: assert property (
    $past(rst_n) && $past(rst_n, 2) |-> $stable(run_mode) && $stable(vector_fetch_addr))
    else $error("mode changed after reset");
  a_vector_run: assert property (
    vector_fetch_addr == (run_mode ? RESET_VECTOR : 16'h0000))
    else $error("vector wrong");
endmodule // pcfp_pin_control_monitor

// ==== sim/testbench.sv ====
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pcfp_pkg::*;
  typedef struct {int pin; logic [3:0] mask; logic [2:0] owner;} pcfp_row_type;
  logic sys_clk = 1'b0;
  logic rst_n, avs_read, avs_write, avs_waitrequest, debug_mode_select_pin, run_mode;
  logic [ADDR_WIDTH-1:0] avs_address;
  logic [DATA_WIDTH-1:0] avs_writedata, avs_readdata, rd;
  pcfp_req_type [PIN_COUNT-1:0] port_req;
  pcfp_req_type [PIN_COUNT-1:0][ALT_COUNT-1:0] alt_req, alt_v;
  pcfp_req_type twi_sda_req, twi_scl_req, debug_req;
  logic [PIN_COUNT-1:0] kbi_rising, adc_en, analog_comparator_en, pad_out, pad_oe, pad_pull_en;
  logic [PIN_COUNT-1:0] pad_pull_down, pad_slew, pad_high_drive, adc_connect, analog_comparator_connect;
  logic [2:0] pin_owner [PIN_COUNT];
  logic [15:0] vector_fetch_addr;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  int p;
  pcfp_row_type rows [8] = '{'{0, 4'h0, 3'h0}, '{1, 4'h1, 3'h1}, '{5, 4'h3, 3'h2},
    '{8, 4'h7, 3'h3}, '{0, 4'hf, 3'h4}, '{5, 4'ha, 3'h4}, '{1, 4'h5, 3'h3}, '{8, 4'h6, 3'h3}};

  pcfp_pin_control pcfp_pin_control_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .port_req(port_req), .alt_req(alt_req),
    .twi_sda_req(twi_sda_req), .twi_scl_req(twi_scl_req), .debug_req(debug_req),
    .kbi_rising(kbi_rising), .adc_en(adc_en), .analog_comparator_en(analog_comparator_en),
    .debug_mode_select_pin(debug_mode_select_pin), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pull_en(pad_pull_en), .pad_pull_down(pad_pull_down), .pad_slew(pad_slew),
    .pad_high_drive(pad_high_drive), .adc_connect(adc_connect), .analog_comparator_connect(analog_comparator_connect),
    .pin_owner(pin_owner), .run_mode(run_mode), .vector_fetch_addr(vector_fetch_addr));

  always #10 sys_clk = ~sys_clk;

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Request held until waitrequest is sampled low; only the watchdog ends a hang
  task automatic bus_write(input logic [ADDR_WIDTH-1:0] a, input logic [DATA_WIDTH-1:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    tick(1);
  endtask

  task automatic expect_reg(input logic [ADDR_WIDTH-1:0] a, input logic [DATA_WIDTH-1:0] e);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    tick(1);
    check("register", rd, e);
  endtask

  task automatic wrap_up;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles > 3000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    rst_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    port_req = '0;
    alt_req = '0;
    alt_v = '0;
    twi_sda_req = '0;
    twi_scl_req = '0;
    debug_req = '0;
    kbi_rising = '0;
    adc_en = '0;
    analog_comparator_en = '0;
    debug_mode_select_pin = 1'b1;
    tick(12);
    rst_n <= 1'b1;
    tick(2);
    check("pull", 32'(pad_pull_en), 32'h0);
    check("oe", 32'(pad_oe), 32'h0);
    check("vector", 32'(vector_fetch_addr), 32'h0000fffe);
    expect_reg(OFS_PULL_B, 32'h0);
    expect_reg(OFS_SLEW_A, 32'h3f);
    expect_reg(OFS_SLEW_B, 32'hff);
    expect_reg(OFS_DRIVE_A, 32'h0);
    expect_reg(OFS_OPTIONS, 32'h2);
    expect_reg(OFS_STATUS, 32'h3);
    bus_write(6'h3c, 32'hffffffff);
    expect_reg(6'h3c, 32'h0);
    bus_write(OFS_PULL_A, 32'h3f);
    bus_write(OFS_PULL_B, 32'hff);
    $display("test reset done");
    foreach (rows[i]) begin
      p = rows[i].pin;
      for (int k = 0; k < ALT_COUNT; k++) begin
        alt_v[p][k] = '{en: rows[i].mask[k], oe: 1'b1, dout: ~k[0]};
      end
      alt_req <= alt_v;
      tick(2);
      check("owner", 32'(pin_owner[p]), 32'(rows[i].owner));
      check("oe", 32'(pad_oe[p]), 32'(rows[i].owner != 3'h0));
      check("out", 32'(pad_out[p]), 32'(rows[i].owner[0]));
      check("pull", 32'(pad_pull_en[p]), 32'(rows[i].owner == 3'h0));
      check("slew", 32'(pad_slew[p]), 32'(rows[i].owner != 3'h0));
      alt_v = '0;
    end
    $display("test priority done");
    alt_req <= '0;
    kbi_rising <= 14'h0200;
    tick(2);
    check("pulldown", 32'(pad_pull_down), 32'h200);
    alt_v[0][0] = '{en: 1'b1, oe: 1'b1, dout: 1'b1};
    alt_req <= alt_v;
    adc_en <= 14'h0001;
    analog_comparator_en <= 14'h0001;
    tick(2);
    check("analog oe", 32'(pad_oe[0]), 32'h0);
    check("analog pull", 32'(pad_pull_en[0]), 32'h0);
    check("analog conn", 32'({adc_connect[0], analog_comparator_connect[0]}), 32'h3);
    $display("test kbi analog done");
    alt_req <= '0;
    adc_en <= '0;
    analog_comparator_en <= '0;
    port_req[6] <= '{en: 1'b1, oe: 1'b1, dout: 1'b1};
    bus_write(OFS_DRIVE_B, 32'h05);
    tick(2);
    check("drive", 32'(pad_high_drive), 32'h140);
    twi_sda_req <= '{en: 1'b1, oe: 1'b1, dout: 1'b1};
    tick(2);
    check("twi a", 32'(pin_owner[2]), 32'h2);
    expect_reg(OFS_OE_STATUS, 32'h44);
    bus_write(OFS_OPTIONS, 32'h3);
    tick(2);
    check("twi b", 32'({pin_owner[12], pin_owner[2]}), 32'h10);
    debug_req <= '{en: 1'b1, oe: 1'b1, dout: 1'b0};
    tick(2);
    check("debug", 32'(pin_owner[4]), 32'h4);
    bus_write(OFS_OPTIONS, 32'h1);
    tick(2);
    check("debug off", 32'(pin_owner[4]), 32'h0);
    $display("test routing done");
    debug_mode_select_pin <= 1'b0;
    rst_n <= 1'b0;
    tick(12);
    rst_n <= 1'b1;
    tick(3);
    check("run", 32'({run_mode, vector_fetch_addr}), 32'h0);
    expect_reg(OFS_OPTIONS, 32'h2);
    $display("test second reset done");
    wrap_up();
  end
endmodule // testbench

bind pcfp_pin_control pcfp_pin_control_monitor pcfp_pin_control_monitor_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .kbi_rising(kbi_rising), .adc_en(adc_en),
  .analog_comparator_en(analog_comparator_en), .debug_mode_select_pin(debug_mode_select_pin), .pad_oe(pad_oe),
  .pad_pull_en(pad_pull_en), .pad_pull_down(pad_pull_down), .pad_slew(pad_slew),
  .adc_connect(adc_connect), .analog_comparator_connect(analog_comparator_connect), .run_mode(run_mode),
  .vector_fetch_addr(vector_fetch_addr));
